// ### hdl/dcl_pkg.sv
package dcl_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 125000000;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned MS_CYCLES      = CLK_HZ / MS_PER_S;  // cycles per millisecond
    localparam logic [15:0] OPER_MS        = 16'd150;            // activity pulse length
    localparam logic [15:0] MIN_PULSE_MS   = 16'd1000;           // earliest early withdrawal
    localparam logic [15:0] PULSE_MS_MIN   = 16'd100;
    localparam logic [15:0] PULSE_MS_MAX   = 16'd60000;
    localparam logic [15:0] PULSE_MS_RST   = 16'd1000;
    localparam logic [15:0] INTER_MS_MIN   = 16'd20;
    localparam logic [15:0] INTER_MS_MAX   = 16'd60000;
    localparam logic [15:0] INTER_MS_RST   = 16'd10000;

    // ------------------------------------------------------------
    // register word indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_COMMAND     = 4'h0;  // wo: [0] direction, [1] source remote
    localparam logic [3:0] REG_PULSE_MS    = 4'h1;  // rw: pulse duration in ms
    localparam logic [3:0] REG_INTER_MS    = 4'h2;  // rw: max intermediate time in ms
    localparam logic [3:0] REG_STATUS      = 4'h3;  // ro: block state
    localparam logic [3:0] REG_OP_COUNT    = 4'h4;  // ro count, any write clears it
    localparam logic [3:0] REG_IRQ_STATUS  = 4'h5;  // ro sticky events
    localparam logic [3:0] REG_IRQ_CLEAR   = 4'h6;  // wo write one to clear
    localparam logic [3:0] REG_IRQ_ENABLE  = 4'h7;  // rw mask

    // command and status fields
    localparam int CMD_DIR_BIT    = 0;  // 0 open, 1 close
    localparam int CMD_SRC_BIT    = 1;  // 0 local, 1 remote
    localparam int ST_CODE_LSB    = 0;
    localparam int ST_OPENED_BIT  = 2;
    localparam int ST_CLOSED_BIT  = 3;
    localparam int ST_OPEN_BIT    = 4;
    localparam int ST_CLOSE_BIT   = 5;
    localparam int ST_OPER_BIT    = 6;

    // event bits
    localparam int EV_STATE       = 0;  // position state code changed
    localparam int EV_REFUSED     = 1;  // command written but not executed
    localparam int EV_ISSUED      = 2;  // command pulse started
    localparam int EV_WIDTH       = 3;

    // position state codes
    typedef enum logic [1:0] {
        DCL_POS_INTER = 2'h0,
        DCL_POS_OFF   = 2'h1,
        DCL_POS_ON    = 2'h2,
        DCL_POS_BAD   = 2'h3
    } dcl_pos_t;
endpackage : dcl_pkg

// ### hdl/dcl_disconnector_ctrl.sv
// What this block does
// - an accepted open command drives open_command_pulse for the pulse duration setting.
// - an accepted close command drives close_command_pulse for the pulse duration setting.
// - each switching operation reached while operation_pulse is low gives one 150 ms pulse on operation_pulse.
// - closed_filtered follows the filtered on state of the position inputs.
// - opened_filtered follows the filtered off state of the position inputs.
// - the operation counter adds one at each rising edge of operation_pulse.
// - a counter reset request from software clears the operation counter.
// - position code is 0 intermediate, 1 off, 2 on, 3 bad from the two position inputs.
// - each change of the position code raises a state event carrying the new code.
// - command value off gives an open pulse and value on gives a close pulse.
// - a command runs only with its source permission and its direction permit both active.
// - all timing runs from an exact millisecond tick, well inside 5 percent or 15 ms.
// - pulse duration is set from 100 to 60000 ms in 1 ms steps, default 1000 ms.
// - a command pulse ends early on confirmed position, but never before 1000 ms.
// - missing valid position is reported intermediate only after the max intermediate time.
// - while process_block is active no command is executed.
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module dcl_disconnector_ctrl #(
    parameter int unsigned MS_CYCLES = dcl_pkg::MS_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        local_permit,
    input  wire logic        remote_permit,
    input  wire logic        open_permit,
    input  wire logic        close_permit,
    input  wire logic        process_block,
    input  wire logic        open_position_input,
    input  wire logic        closed_position_input,
    output logic             open_command_pulse,
    output logic             close_command_pulse,
    output logic             operation_pulse,
    output logic             opened_filtered,
    output logic             closed_filtered,
    output logic [1:0]       position_state_code,
    output logic             state_event,
    output logic [1:0]       state_event_code,
    output logic             irq
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // clamp a millisecond setting into its legal range
    function automatic logic [15:0] dcl_clamp(input logic [31:0] v, input logic [15:0] lo,
                                              input logic [15:0] hi);
        if (v < {16'h0000, lo}) begin
            return lo;
        end else if (v > {16'h0000, hi}) begin
            return hi;
        end
        return v[15:0];
    endfunction : dcl_clamp

    // saturating millisecond count step
    function automatic logic [15:0] dcl_inc(input logic [15:0] v, input logic tick);
        return (tick && v != 16'hffff) ? v + 16'h0001 : v;
    endfunction : dcl_inc

    // ------------------------------------------------------------
    // millisecond timebase
    // ------------------------------------------------------------
    localparam int unsigned DIV_W = $clog2(MS_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);
    logic [DIV_W-1:0] div_ff;
    wire              ms_tick = (div_ff == DIV_LAST);

    // divider wraps once per millisecond
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= ms_tick ? '0 : div_ff + DIV_W'(1);
        end
    end

    // ------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------
    logic        ack_ff;
    logic [15:0] pulse_ms_ff;
    logic [15:0] inter_ms_ff;
    localparam int EV_BITS = dcl_pkg::EV_WIDTH;
    logic [31:0] op_count_ff;
    logic [EV_BITS-1:0] irq_status_ff;
    logic [EV_BITS-1:0] irq_enable_ff;

    wire wr_take  = avs_write & ack_ff;
    wire wr_cmd   = wr_take && avs_address == dcl_pkg::REG_COMMAND;
    wire wr_pulse = wr_take && avs_address == dcl_pkg::REG_PULSE_MS;
    wire wr_inter = wr_take && avs_address == dcl_pkg::REG_INTER_MS;
    wire wr_cnt   = wr_take && avs_address == dcl_pkg::REG_OP_COUNT;
    wire wr_clr   = wr_take && avs_address == dcl_pkg::REG_IRQ_CLEAR;
    wire wr_ena   = wr_take && avs_address == dcl_pkg::REG_IRQ_ENABLE;

    // one wait cycle, then the answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

    wire [31:0] status_word = {25'h0, operation_pulse, close_command_pulse, open_command_pulse,
                               closed_filtered, opened_filtered, position_state_code};
    logic [31:0] rd_mux;
    // read data selection, unmapped reads zero
    always_comb begin
        case (avs_address)
            dcl_pkg::REG_PULSE_MS:   rd_mux = {16'h0000, pulse_ms_ff};
            dcl_pkg::REG_INTER_MS:   rd_mux = {16'h0000, inter_ms_ff};
            dcl_pkg::REG_STATUS:     rd_mux = status_word;
            dcl_pkg::REG_OP_COUNT:   rd_mux = op_count_ff;
            dcl_pkg::REG_IRQ_STATUS: rd_mux = {29'h0, irq_status_ff};
            dcl_pkg::REG_IRQ_ENABLE: rd_mux = {29'h0, irq_enable_ff};
            default:                 rd_mux = 32'h0000_0000;
        endcase
    end

    // bus handshake and settings
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            pulse_ms_ff  <= dcl_pkg::PULSE_MS_RST;
            inter_ms_ff  <= dcl_pkg::INTER_MS_RST;
            irq_enable_ff <= '0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
            if (avs_read && !ack_ff) begin
                avs_readdata <= rd_mux;
            end
            if (wr_pulse) begin
                pulse_ms_ff <= dcl_clamp(avs_writedata, dcl_pkg::PULSE_MS_MIN, dcl_pkg::PULSE_MS_MAX);
            end
            if (wr_inter) begin
                inter_ms_ff <= dcl_clamp(avs_writedata, dcl_pkg::INTER_MS_MIN, dcl_pkg::INTER_MS_MAX);
            end
            if (wr_ena) begin
                irq_enable_ff <= avs_writedata[EV_BITS-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // position decode and filter
    // ------------------------------------------------------------
    wire [1:0] raw_code = {closed_position_input, open_position_input};
    wire       raw_inter = (raw_code == dcl_pkg::DCL_POS_INTER);
    logic [15:0] inter_cnt_ff;
    logic [1:0]  pos_ff;
    wire         inter_expired = (inter_cnt_ff >= inter_ms_ff);
    wire [1:0]   nxt_pos = !raw_inter ? raw_code : (inter_expired ? raw_code : pos_ff);
    wire         pos_change = (nxt_pos != pos_ff);

    // hold last valid code until intermediate time runs out
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            inter_cnt_ff <= 16'h0000;
            pos_ff       <= dcl_pkg::DCL_POS_INTER;
        end else begin
            inter_cnt_ff <= raw_inter ? dcl_inc(inter_cnt_ff, ms_tick) : 16'h0000;
            pos_ff       <= nxt_pos;
        end
    end
    assign position_state_code = pos_ff;
    assign opened_filtered     = (pos_ff == dcl_pkg::DCL_POS_OFF);
    assign closed_filtered     = (pos_ff == dcl_pkg::DCL_POS_ON);

    // state event carries the new code
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_event      <= 1'b0;
            state_event_code <= 2'h0;
        end else begin
            state_event <= pos_change;
            if (pos_change) begin
                state_event_code <= nxt_pos;
            end
        end
    end

    // ------------------------------------------------------------
    // command pulses
    // ------------------------------------------------------------
    logic        open_ff;
    logic        close_ff;
    logic [15:0] cmd_ms_ff;
    wire busy      = open_ff | close_ff;
    wire cmd_dir   = avs_writedata[dcl_pkg::CMD_DIR_BIT];
    wire src_ok    = avs_writedata[dcl_pkg::CMD_SRC_BIT] ? remote_permit : local_permit;
    wire dir_ok    = cmd_dir ? close_permit : open_permit;
    wire cmd_go    = wr_cmd & src_ok & dir_ok & ~process_block & ~busy;
    wire cmd_refus = wr_cmd & ~cmd_go;
    wire confirmed = open_ff ? (raw_code == dcl_pkg::DCL_POS_OFF) : (raw_code == dcl_pkg::DCL_POS_ON);
    wire min_done  = (cmd_ms_ff >= dcl_pkg::MIN_PULSE_MS);
    wire full_done = (cmd_ms_ff >= pulse_ms_ff);
    wire cmd_end   = busy & (full_done | (confirmed & min_done));

    // pulse start, count and end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            open_ff   <= 1'b0;
            close_ff  <= 1'b0;
            cmd_ms_ff <= 16'h0000;
        end else if (cmd_go) begin
            open_ff   <= ~cmd_dir;
            close_ff  <= cmd_dir;
            cmd_ms_ff <= 16'h0000;
        end else if (cmd_end) begin
            open_ff   <= 1'b0;
            close_ff  <= 1'b0;
            cmd_ms_ff <= 16'h0000;
        end else if (busy) begin
            cmd_ms_ff <= dcl_inc(cmd_ms_ff, ms_tick);
        end
    end
    assign open_command_pulse  = open_ff;
    assign close_command_pulse = close_ff;

    // ------------------------------------------------------------
    // operation pulse and counter
    // ------------------------------------------------------------
    logic        oper_ff;
    logic [15:0] oper_ms_ff;
    wire oper_start = pos_change & ~oper_ff &
                      (nxt_pos == dcl_pkg::DCL_POS_OFF || nxt_pos == dcl_pkg::DCL_POS_ON);
    wire oper_end   = oper_ff & (oper_ms_ff >= dcl_pkg::OPER_MS);

    // fixed 150 ms pulse, counted once per start
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            oper_ff     <= 1'b0;
            oper_ms_ff  <= 16'h0000;
            op_count_ff <= 32'h0000_0000;
        end else begin
            if (oper_start) begin
                oper_ff    <= 1'b1;
                oper_ms_ff <= 16'h0000;
            end else if (oper_end) begin
                oper_ff    <= 1'b0;
            end else if (oper_ff) begin
                oper_ms_ff <= dcl_inc(oper_ms_ff, ms_tick);
            end
            if (wr_cnt) begin
                op_count_ff <= {31'h0, oper_start};
            end else if (oper_start) begin
                op_count_ff <= op_count_ff + 32'h0000_0001;
            end
        end
    end
    assign operation_pulse = oper_ff;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [EV_BITS-1:0] ev_set = {cmd_go, cmd_refus, pos_change};
    wire [EV_BITS-1:0] ev_clr = wr_clr ? avs_writedata[EV_BITS-1:0] : '0;

    // sticky events, a new event beats the clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_ff <= '0;
        end else begin
            irq_status_ff <= (irq_status_ff & ~ev_clr) | ev_set;
        end
    end
    assign irq = |(irq_status_ff & irq_enable_ff);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_open_go;
        cmd_go && !cmd_dir;
    endsequence
    sequence s_close_go;
        cmd_go && cmd_dir;
    endsequence

    AST_OPEN_START: assert property (@(posedge clock) disable iff (!reset_n)
        s_open_go |=> open_command_pulse && !close_command_pulse)
        else $error("open command did not start open pulse");
    AST_CLOSE_START: assert property (@(posedge clock) disable iff (!reset_n)
        s_close_go |=> close_command_pulse && !open_command_pulse)
        else $error("close command did not start close pulse");
    AST_PULSE_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
        (busy && cmd_ms_ff < pulse_ms_ff && cmd_ms_ff < dcl_pkg::MIN_PULSE_MS) |=> busy)
        else $error("command pulse ended too early");
    AST_PULSE_END: assert property (@(posedge clock) disable iff (!reset_n)
        (busy && cmd_ms_ff >= pulse_ms_ff && !cmd_go) |=> !busy)
        else $error("command pulse overran its duration");
    AST_BLOCKED: assert property (@(posedge clock) disable iff (!reset_n)
        (wr_cmd && (process_block || busy)) |=> !$rose(open_ff) && !$rose(close_ff))
        else $error("command executed while blocked");
    AST_PERMIT: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(busy) |-> $past(src_ok && dir_ok && !process_block))
        else $error("command executed without permission");
    AST_DECODE: assert property (@(posedge clock) disable iff (!reset_n)
        !raw_inter |=> position_state_code == $past(raw_code))
        else $error("position code does not follow inputs");
    AST_FILTERED: assert property (@(posedge clock) disable iff (!reset_n)
        (closed_filtered |-> !$past(open_position_input)) and (opened_filtered |-> !$past(closed_position_input)))
        else $error("opened and closed outputs inconsistent");
    AST_EVENT: assert property (@(posedge clock) disable iff (!reset_n)
        $changed(position_state_code) |-> state_event ##0 state_event_code == position_state_code)
        else $error("state change without event");
    AST_OPER_COUNT: assert property (@(posedge clock) disable iff (!reset_n)
        ($rose(operation_pulse) && !$past(wr_cnt)) |-> op_count_ff == $past(op_count_ff) + 32'h1)
        else $error("operation counter missed a pulse");
    AST_COUNT_CLR: assert property (@(posedge clock) disable iff (!reset_n)
        (wr_cnt && !oper_start) |=> op_count_ff == 32'h0)
        else $error("operation counter not cleared");
    AST_OPER_LEN: assert property (@(posedge clock) disable iff (!reset_n)
        oper_start |=> operation_pulse ##1 (operation_pulse && oper_ms_ff <= dcl_pkg::OPER_MS)[*8])
        else $error("operation pulse too short");
endmodule : dcl_disconnector_ctrl

// ### dv/dcl_switch_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// disconnector with open and closed auxiliary contacts
// ------------------------------------------------------------
module dcl_switch_model #(
    parameter int unsigned TRAVEL = 40
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic open_command_pulse,
    input  wire logic close_command_pulse,
    input  wire logic force_en,
    input  wire logic force_open,
    input  wire logic force_closed,
    output logic      open_position_input,
    output logic      closed_position_input
);
    logic       closed_ff;
    logic [7:0] move_ff;

    // travel starts while a pulse asks for the other position
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            closed_ff <= 1'b0;
            move_ff   <= 8'h00;
        end else if (move_ff != 8'h00) begin
            move_ff <= move_ff - 8'h01;
            if (move_ff == 8'h01)
                closed_ff <= !closed_ff;
        end else if ((close_command_pulse && !closed_ff) || (open_command_pulse && closed_ff)) begin
            move_ff <= TRAVEL[7:0];
        end
    end

    // both contacts open during travel, override for fault cases
    assign open_position_input   = force_en ? force_open : (move_ff == 8'h00) && !closed_ff;
    assign closed_position_input = force_en ? force_closed : (move_ff == 8'h00) && closed_ff;
endmodule : dcl_switch_model

// ### dv/dcl_disconnector_control_logic_bench.sv
`timescale 1ns/10ps
module dcl_disconnector_control_logic_bench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clock, reset_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        local_permit, remote_permit, open_permit, close_permit, process_block;
    logic        force_en, force_open, force_closed, open_position_input, closed_position_input;
    logic        open_command_pulse, close_command_pulse, operation_pulse;
    logic        opened_filtered, closed_filtered, state_event;
    logic [1:0]  position_state_code, state_event_code, ev_code;
    logic [15:0] run_c [3];
    logic [15:0] width_c [3];
    logic [2:0]  pls;
    logic [4:0]  refuse_tab [4] = '{5'h06, 5'h1a, 5'h0c, 5'h0f};  // src, local, remote, open, block
    int          bad_count, n_checks;

    assign pls = {operation_pulse, close_command_pulse, open_command_pulse};

    dcl_disconnector_ctrl #(.MS_CYCLES(8)) uut (
        .clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .local_permit(local_permit), .remote_permit(remote_permit),
        .open_permit(open_permit), .close_permit(close_permit), .process_block(process_block),
        .open_position_input(open_position_input), .closed_position_input(closed_position_input),
        .open_command_pulse(open_command_pulse), .close_command_pulse(close_command_pulse),
        .operation_pulse(operation_pulse), .opened_filtered(opened_filtered),
        .closed_filtered(closed_filtered), .position_state_code(position_state_code),
        .state_event(state_event), .state_event_code(state_event_code), .irq(irq));

    dcl_switch_model #(.TRAVEL(40)) sw (
        .clock(clock), .reset_n(reset_n), .open_command_pulse(open_command_pulse),
        .close_command_pulse(close_command_pulse), .force_en(force_en), .force_open(force_open),
        .force_closed(force_closed), .open_position_input(open_position_input),
        .closed_position_input(closed_position_input));

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // pulse widths in cycles and last event code
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                run_c[i]   <= 16'h0000;
                width_c[i] <= 16'h0000;
            end
            ev_code <= 2'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                run_c[i] <= pls[i] ? run_c[i] + 16'h0001 : 16'h0000;
                if (!pls[i] && run_c[i] != 16'h0000)
                    width_c[i] <= run_c[i];
            end
            if (state_event === 1'b1)
                ev_code <= state_event_code;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        chk({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
    endtask : chk_rng

    // one avalon transfer, held until waitrequest is sampled low at a rising edge
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= wd;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        chk({31'h0, n < 64}, 32'h1);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(negedge clock);  // outputs settled after the taking edge
    endtask : xfer

    task automatic wait_fall(input int i);
        int n;
        n = 0;
        @(negedge clock);
        while (pls[i] !== 1'b0 && n < 20000) begin
            @(negedge clock);
            n++;
        end
        chk({31'h0, n < 20000}, 32'h1);
        @(negedge clock);  // width capture lands one edge after the fall
    endtask : wait_fall

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // watchdog
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {local_permit, remote_permit, open_permit, close_permit, process_block} = 5'h1e;
        {force_en, force_open, force_closed} = 3'h0;
        bad_count = 0;
        n_checks = 0;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        xfer(1'b0, dcl_pkg::REG_PULSE_MS, 32'h0);
        chk(rd, {16'h0, dcl_pkg::PULSE_MS_RST});
        xfer(1'b0, dcl_pkg::REG_INTER_MS, 32'h0);
        chk(rd, {16'h0, dcl_pkg::INTER_MS_RST});
        xfer(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        chk({30'h0, position_state_code}, 32'h1);
        chk({30'h0, ev_code}, 32'h1);
        chk({31'h0, opened_filtered}, 32'h1);
        xfer(1'b1, dcl_pkg::REG_OP_COUNT, 32'h0);
        xfer(1'b0, dcl_pkg::REG_OP_COUNT, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, dcl_pkg::REG_PULSE_MS, 32'h32);
        xfer(1'b0, dcl_pkg::REG_PULSE_MS, 32'h0);
        chk(rd, {16'h0, dcl_pkg::PULSE_MS_MIN});
        xfer(1'b1, dcl_pkg::REG_PULSE_MS, 32'h11170);
        xfer(1'b0, dcl_pkg::REG_PULSE_MS, 32'h0);
        chk(rd, {16'h0, dcl_pkg::PULSE_MS_MAX});
        xfer(1'b1, dcl_pkg::REG_PULSE_MS, 32'h64);
        xfer(1'b1, dcl_pkg::REG_INTER_MS, 32'h14);
        $display("test reset and settings done");
        wait_fall(2);
        xfer(1'b1, dcl_pkg::REG_COMMAND, 32'h1);
        xfer(1'b1, dcl_pkg::REG_COMMAND, 32'h0);
        wait_fall(1);
        chk_rng(width_c[1], 16'h0318, 16'h0328);
        chk({15'h0, width_c[0], open_command_pulse}, 32'h0);
        chk({30'h0, position_state_code}, 32'h2);
        chk({30'h0, ev_code}, 32'h2);
        chk({30'h0, closed_filtered, opened_filtered}, 32'h2);
        xfer(1'b0, dcl_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h4a);
        wait_fall(2);
        chk_rng(width_c[2], 16'h04a8, 16'h04b8);
        xfer(1'b0, dcl_pkg::REG_OP_COUNT, 32'h0);
        chk(rd, 32'h1);
        $display("test close done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            {local_permit, remote_permit, open_permit, process_block} <= refuse_tab[i][3:0];
            xfer(1'b1, dcl_pkg::REG_IRQ_CLEAR, 32'h7);
            xfer(1'b1, dcl_pkg::REG_COMMAND, {30'h0, refuse_tab[i][4], 1'b0});
            repeat (4) @(negedge clock);
            chk({31'h0, open_command_pulse}, 32'h0);
            xfer(1'b0, dcl_pkg::REG_IRQ_STATUS, 32'h0);
            chk({31'h0, rd[dcl_pkg::EV_REFUSED]}, 32'h1);
        end
        $display("test refusals done");
        @(posedge clock);
        {local_permit, remote_permit, open_permit, process_block} <= 4'h6;
        xfer(1'b1, dcl_pkg::REG_PULSE_MS, 32'h4b0);
        xfer(1'b1, dcl_pkg::REG_COMMAND, 32'h2);
        wait_fall(0);
        chk_rng(width_c[0], 16'h1f38, 16'h1f48);
        chk({30'h0, closed_filtered, opened_filtered}, 32'h1);
        $display("test remote open done");
        xfer(1'b1, dcl_pkg::REG_IRQ_CLEAR, 32'h7);
        xfer(1'b1, dcl_pkg::REG_IRQ_ENABLE, 32'h1);
        chk({31'h0, irq}, 32'h0);
        @(posedge clock);
        {force_en, force_open, force_closed} <= 3'h7;
        repeat (3) @(negedge clock);
        chk({30'h0, position_state_code}, 32'h3);
        chk({30'h0, ev_code}, 32'h3);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, dcl_pkg::REG_IRQ_ENABLE, 32'h0);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, dcl_pkg::REG_IRQ_ENABLE, 32'h1);
        xfer(1'b1, dcl_pkg::REG_IRQ_CLEAR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        @(posedge clock);
        {force_open, force_closed} <= 2'h0;
        repeat (100) @(negedge clock);
        chk({30'h0, position_state_code}, 32'h3);
        repeat (100) @(negedge clock);
        chk({30'h0, position_state_code}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        $display("test fault states done");
        wrap_up();
    end
endmodule : dcl_disconnector_control_logic_bench
